// File: rtl/dbgfa_top.v
/*
 * trace fifo low byte readout and comparator a with extension controls.
 * assumes a synchronous register port on core_clk, a capture strobe from
 * the trigger logic, and core bus signals valid in the cycle they are sampled.
 */
// The implementer's own choice: strobed register access.
// Summary of operation
// - low byte register returns word bits 7..0
// - reading low byte advances fifo read pointer
// - event modes: low byte alone suffices
// - direction enable bit includes bus direction
// - direction value: 0 write, 1 read
// - page qualifier must equal paged-access flag
// - paged access: page index above addr 13..0
// - unpaged: bit16 zero or linear pointer
// - extension bit 0 compares address bit 16
// - end-trace reset keeps comparator a registers only with debug_module_enable set and begin_trigger_sel clear
// - low compare register matches address 7..0
// - high byte gives word bits 15..8
`include "dbgfa_map.vh"

module dbgfa_top #(
    parameter DEPTH = 8,
    parameter AW = 3
)(
    input wire core_clk,
    input wire nrst,
    input wire end_run_reset,
    input wire debug_module_enable,
    input wire begin_trigger_sel,
    input wire event_only_mode,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [15:0] cpu_addr,
    input wire [16:0] linear_addr,
    input wire linear_sel,
    input wire [2:0] program_page,
    input wire paged_access,
    input wire bus_read,
    input wire bus_valid,
    input wire capture,
    input wire [23:0] capture_word,
    output wire fifo_full,
    output reg cmp_a_match
);
    // ****************************************
    // registers and reset keep decision
    // ****************************************
    localparam [AW:0] DEPTH_W = DEPTH;

    // comparator a setup
    reg [7:0] cmp_a_high_reg;
    reg [7:0] cmp_a_low_reg;
    reg [7:0] cmp_a_ext_reg;
    reg [7:0] cmp_a_high_next;
    reg [7:0] cmp_a_low_next;
    reg [7:0] cmp_a_ext_next;
    wire keep_on_reset;
    wire wr_cmp_high;
    wire wr_cmp_low;
    wire wr_cmp_ext;

    // fifo state
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    reg [23:0] bypass_word_reg;
    reg bypass_sel_reg;
    wire [23:0] fifo_word;
    wire [23:0] mem_word;
    wire [23:0] wr_word;
    wire [AW-1:0] rd_addr_next;
    wire [7:0] count_byte;
    wire fifo_empty;
    wire rd_fifo_low;
    wire pop;
    wire push;

    // comparator a match terms
    wire [16:0] core_addr;
    wire [16:0] cmp_addr_exp;
    wire [16:0] addr_bit_hit;
    wire dir_ok;
    wire page_ok;
    wire addr_ok;

    // end-trace reset with trace armed keeps the comparator setup
    assign keep_on_reset = end_run_reset & debug_module_enable & ~begin_trigger_sel;

    // ****************************************
    // register port decode
    // ****************************************
    function is_reg;
        input [3:0] addr;
        input [3:0] ofs;
        begin
            is_reg = (addr == ofs);
        end
    endfunction

    // read view of every mapped register
    function [7:0] read_mux;
        input [3:0] addr;
        input [7:0] high;
        input [7:0] low;
        input [7:0] ext;
        input [23:0] word;
        input [7:0] count;
        begin
            case (addr)
                `DBGFA_OFS_CMP_A_HIGH: read_mux = high;
                `DBGFA_OFS_CMP_A_LOW: read_mux = low;
                `DBGFA_OFS_FIFO_HIGH: read_mux = word[15:8];
                `DBGFA_OFS_FIFO_LOW: read_mux = word[7:0];
                `DBGFA_OFS_CMP_A_EXT: read_mux = ext;
                `DBGFA_OFS_FIFO_EXT: read_mux = word[23:16];
                `DBGFA_OFS_FIFO_COUNT: read_mux = count;
                default: read_mux = 8'h00;
            endcase
        end
    endfunction

    assign wr_cmp_high = reg_wr && is_reg(reg_addr, `DBGFA_OFS_CMP_A_HIGH);
    assign wr_cmp_low = reg_wr && is_reg(reg_addr, `DBGFA_OFS_CMP_A_LOW);
    assign wr_cmp_ext = reg_wr && is_reg(reg_addr, `DBGFA_OFS_CMP_A_EXT);
    assign rd_fifo_low = reg_rd && is_reg(reg_addr, `DBGFA_OFS_FIFO_LOW);

    always @*
    begin
        cmp_a_high_next = cmp_a_high_reg;
        if (wr_cmp_high)
        begin
            cmp_a_high_next = reg_wdata;
        end
    end

    always @*
    begin
        cmp_a_low_next = cmp_a_low_reg;
        if (wr_cmp_low)
        begin
            cmp_a_low_next = reg_wdata;
        end
    end

    // bits 4..1 are not implemented and read as zero
    always @*
    begin
        cmp_a_ext_next = cmp_a_ext_reg;
        if (wr_cmp_ext)
        begin
            cmp_a_ext_next = reg_wdata & `DBGFA_EXT_WR_MASK;
        end
    end

    // ****************************************
    // comparator a registers
    // ****************************************
    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            if (!keep_on_reset)
            begin
                cmp_a_high_reg <= `DBGFA_RST_BYTE;
            end
        end
        else
        begin
            cmp_a_high_reg <= cmp_a_high_next;
        end
    end

    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            if (!keep_on_reset)
            begin
                cmp_a_low_reg <= `DBGFA_RST_BYTE;
            end
        end
        else
        begin
            cmp_a_low_reg <= cmp_a_low_next;
        end
    end

    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            if (!keep_on_reset)
            begin
                cmp_a_ext_reg <= `DBGFA_RST_BYTE;
            end
        end
        else
        begin
            cmp_a_ext_reg <= cmp_a_ext_next;
        end
    end

    // ****************************************
    // trace fifo pointers
    // ****************************************
    assign fifo_empty = (count_reg == {(AW+1){1'b0}});
    assign fifo_full = (count_reg == DEPTH_W);
    assign count_byte = {{(7-AW){1'b0}}, count_reg};
    // a low read on an empty fifo returns stale data and moves nothing
    assign pop = rd_fifo_low && !fifo_empty;
    assign push = capture && !fifo_full;

    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // ****************************************
    // trace word storage and read bypass
    // ****************************************
    // event words stored with upper bytes cleared
    assign wr_word = event_only_mode ? {16'h0000, capture_word[7:0]} : capture_word;
    assign rd_addr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;

    dbgfa_mem #(
        .WIDTH(24),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_mem (
        .core_clk(core_clk),
        .wr_en(push),
        .wr_addr(wr_ptr_reg),
        .wr_data(wr_word),
        .rd_addr(rd_addr_next),
        .rd_data(mem_word)
    );

    // a word written into the slot being read misses the registered
    // read data, so it is carried here for one cycle
    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            bypass_sel_reg <= 1'b0;
            bypass_word_reg <= 24'h000000;
        end
        else
        begin
            bypass_sel_reg <= push && (wr_ptr_reg == rd_addr_next);
            bypass_word_reg <= wr_word;
        end
    end

    assign fifo_word = bypass_sel_reg ? bypass_word_reg : mem_word;

    // ****************************************
    // read data, one cycle after the strobe
    // ****************************************
    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            reg_rdata <= read_mux(reg_addr, cmp_a_high_reg, cmp_a_low_reg, cmp_a_ext_reg,
                fifo_word, count_byte);
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

    // ****************************************
    // comparator a
    // ****************************************
    assign core_addr = paged_access ? {program_page, cpu_addr[13:0]}
        : (linear_sel ? linear_addr : {1'b0, cpu_addr});
    assign cmp_addr_exp = {cmp_a_ext_reg[`DBGFA_BIT_ADDR16], cmp_a_high_reg, cmp_a_low_reg};

    // one equality per core address bit
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < 17; bit_idx = bit_idx + 1)
        begin : g_addr_bit
            assign addr_bit_hit[bit_idx] = (core_addr[bit_idx] == cmp_addr_exp[bit_idx]);
        end
    endgenerate

    assign addr_ok = (&addr_bit_hit[7:0])
        && (&addr_bit_hit[15:8])
        && addr_bit_hit[16];

    // ****************************************
    // match qualifiers
    // ****************************************
    assign dir_ok = !cmp_a_ext_reg[`DBGFA_BIT_DIR_ENABLE]
        || (bus_read == cmp_a_ext_reg[`DBGFA_BIT_DIR_VALUE]);
    assign page_ok = (paged_access == cmp_a_ext_reg[`DBGFA_BIT_PAGE_QUAL]);

    always @(posedge core_clk)
    begin
        if (!nrst)
        begin
            cmp_a_match <= 1'b0;
        end
        else
        begin
            cmp_a_match <= bus_valid && addr_ok && page_ok && dir_ok;
        end
    end
endmodule // dbgfa_top

// File: rtl/dbgfa_map.vh
/*
 * register offsets, field positions and reset values of the trace fifo
 * readout and comparator a extension block.
 * assumes inclusion by bare name from the design files.
 */
`ifndef DBGFA_MAP_VH
`define DBGFA_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define DBGFA_OFS_CMP_A_HIGH 4'h0
`define DBGFA_OFS_CMP_A_LOW 4'h1
`define DBGFA_OFS_FIFO_HIGH 4'h6
`define DBGFA_OFS_FIFO_LOW 4'h7
`define DBGFA_OFS_CMP_A_EXT 4'h8
`define DBGFA_OFS_FIFO_EXT 4'hB
`define DBGFA_OFS_FIFO_COUNT 4'hC

// ****************************************
// comparator a extension fields
// ****************************************
`define DBGFA_BIT_DIR_ENABLE 7
`define DBGFA_BIT_DIR_VALUE 6
`define DBGFA_BIT_PAGE_QUAL 5
`define DBGFA_BIT_ADDR16 0
`define DBGFA_EXT_WR_MASK 8'hE1

// ****************************************
// reset values
// ****************************************
`define DBGFA_RST_BYTE 8'h00

`endif

// File: rtl/dbgfa_mem.v
/*
 * small trace word memory with registered read data.
 * assumes one write port and one read port on core_clk.
 */
module dbgfa_mem #(
    parameter WIDTH = 24,
    parameter DEPTH = 8,
    parameter AW = 3
)(
    input wire core_clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge core_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // dbgfa_mem

// File: verif/dbgfa_sva.sv
/* checker of comparator a match and register read timing.
   bound to dbgfa_top, sees its ports only. */
module dbgfa_sva(
    input wire core_clk,
    input wire nrst,
    input wire end_run_reset,
    input wire debug_module_enable,
    input wire begin_trigger_sel,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire [15:0] cpu_addr,
    input wire [16:0] linear_addr,
    input wire linear_sel,
    input wire [2:0] program_page,
    input wire paged_access,
    input wire bus_read,
    input wire bus_valid,
    input wire cmp_a_match
);
    // ****************
    // shadow registers
    // ****************
    logic [7:0] hi_reg, lo_reg, ext_reg;
    logic [16:0] ca;
    logic hit;
    assign ca = paged_access ? {program_page, cpu_addr[13:0]} :
        linear_sel ? linear_addr : {1'b0, cpu_addr};
    assign hit = bus_valid && ca == {ext_reg[0], hi_reg, lo_reg} &&
        ext_reg[5] == paged_access && (!ext_reg[7] || ext_reg[6] == bus_read);
    always @(posedge core_clk)
    begin
        if (!nrst && !(end_run_reset && debug_module_enable && !begin_trigger_sel))
            {hi_reg, lo_reg, ext_reg} <= 24'h000000;
        else if (nrst && reg_wr && reg_addr == 4'h0)
            hi_reg <= reg_wdata;
        else if (nrst && reg_wr && reg_addr == 4'h1)
            lo_reg <= reg_wdata;
        else if (nrst && reg_wr && reg_addr == 4'h8)
            ext_reg <= reg_wdata & 8'hE1;
    end
    // ****************
    // properties
    // ****************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_match_exact: assert property ($past(nrst) |-> cmp_a_match == $past(hit))
        else $error("match differs");
    a_match_idle: assert property (!bus_valid |=> !cmp_a_match)
        else $error("match without cycle");
    a_page_qual: assert property (ext_reg[5] != paged_access |=> !cmp_a_match)
        else $error("page flag ignored");
    a_dir_qual: assert property (ext_reg[7] && ext_reg[6] != bus_read |=> !cmp_a_match)
        else $error("direction ignored");
    a_addr16_cmp: assert property (ca[16] != ext_reg[0] |=> !cmp_a_match)
        else $error("bit 16 ignored");
    a_low_cmp: assert property (ca[7:0] != lo_reg |=> !cmp_a_match)
        else $error("low byte ignored");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside answer");
    a_ext_keep: assert property (reg_rd && reg_addr == 4'h8 |=> reg_rdata == $past(ext_reg))
        else $error("extension readback");
    cover property (cmp_a_match);
    cover property (ext_reg[7] && cmp_a_match);
    cover property (reg_rd && reg_addr == 4'h7);
endmodule // dbgfa_sva

bind dbgfa_top dbgfa_sva u_sva (.*);

// File: verif/dbgfa_bus_model.sv
/* model of the cpu core bus feeding comparator a.
   assumes one bus cycle per req cycle from the bench. */
module dbgfa_bus_model(
    input wire core_clk,
    input wire req,
    input wire [16:0] req_addr,
    input wire [1:0] req_mode,
    input wire req_read,
    output logic [15:0] cpu_addr,
    output logic [16:0] linear_addr,
    output logic linear_sel,
    output logic [2:0] program_page,
    output logic paged_access,
    output logic bus_read,
    output logic bus_valid
);
    // ****************
    // bus drive
    // ****************
    logic [31:0] noise = 32'h00000000;
    always @(posedge core_clk)
        noise <= $urandom;
    always @*
    begin
        {linear_sel, paged_access, bus_read, program_page, cpu_addr} = noise[21:0];
        linear_addr = ~noise[16:0];
        bus_valid = req;
        if (req)
        begin
            paged_access = req_mode == 2'h2;
            linear_sel = req_mode == 2'h1;
            bus_read = req_read;
            if (req_mode == 2'h2)
                {program_page, cpu_addr[13:0]} = req_addr;
            else if (req_mode == 2'h1)
                linear_addr = req_addr;
            else
                cpu_addr = req_addr[15:0];
        end
    end
endmodule // dbgfa_bus_model

// File: verif/tb.sv
/* self-checking bench of dbgfa_top.
   assumes dbgfa_bus_model beside it and default parameters. */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // signals and tasks
    // ****************
    logic core_clk = 1'b0, nrst = 1'b0, end_run_reset = 1'b0, debug_module_enable = 1'b1;
    logic begin_trigger_sel = 1'b0, event_only_mode = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic capture = 1'b0, req = 1'b0, req_read = 1'b0, linear_sel, paged_access, bus_read;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, hi, lo, ext, reg_rdata;
    logic [23:0] capture_word = 24'h000000, q[$];
    logic [16:0] req_addr = 17'h00000, a, linear_addr;
    logic [1:0] req_mode = 2'h0;
    logic fifo_full, cmp_a_match, bus_valid;
    logic [15:0] cpu_addr;
    logic [2:0] program_page;
    int err_total = 0, comparisons = 0, cyc = 0;
    dbgfa_top u_dut (.*);
    dbgfa_bus_model u_bus (.*);
    initial
        forever #2 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
            end_sim(1'b1);
    end
    task end_sim(input bit hang);
        if (hang)
            err_total++;
        $display("checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, d};
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] ad, input logic [7:0] exp);
        @(posedge core_clk);
        {reg_rd, reg_addr} <= {1'b1, ad};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task push(input logic [23:0] w);
        @(posedge core_clk);
        {capture, capture_word} <= {1'b1, w};
        @(posedge core_clk);
        capture <= 1'b0;
        if (q.size() < 8)
            q.push_back(event_only_mode ? {16'h0000, w[7:0]} : w);
    endtask
    task rst(input logic b);
        @(posedge core_clk);
        {end_run_reset, begin_trigger_sel, nrst} <= {1'b1, b, 1'b0};
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
    endtask
    function logic expm(input logic [1:0] m, input logic r);
        logic [16:0] ca;
        ca = m == 2'h0 ? {1'b0, a[15:0]} : a;
        return ca == {ext[0], hi, lo} && ext[5] == (m == 2'h2) && (!ext[7] || ext[6] == r);
    endfunction
    // ****************
    // tests
    // ****************
    initial
    begin
        void'($urandom(32'hF708));
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        rd(4'hF, 8'h00);
        for (int i = 0; i < 64; i++)
        begin
            {hi, lo, ext} = 24'($urandom);
            ext = {i[1:0], ext[5], 4'h0, ext[0]};
            wr(4'h0, hi);
            wr(4'h1, lo);
            wr(4'h8, ext | 8'h1E);
            rd(4'h8, ext);
            a = i[3] ? {ext[0], hi, lo} : 17'($urandom);
            req_mode <= 2'($urandom_range(2));
            @(posedge core_clk);
            {req, req_addr, req_read} <= {1'b1, a, i[2]};
            @(posedge core_clk);
            req <= 1'b0;
            #1 chk({7'h00, cmp_a_match}, {7'h00, expm(req_mode, i[2])});
        end
        $display("test comparator done");
        rst(1'b0);
        rd(4'h8, ext);
        rd(4'h0, hi);
        rd(4'h1, lo);
        rst(1'b1);
        rd(4'h8, 8'h00);
        $display("test reset done");
        repeat (8) push(24'($urandom));
        #1 chk({7'h00, fifo_full}, 8'h01);
        push(24'($urandom));
        rd(4'hC, 8'h08);
        while (q.size() > 0)
        begin
            rd(4'hB, q[0][23:16]);
            rd(4'h6, q[0][15:8]);
            rd(4'h7, q[0][7:0]);
            void'(q.pop_front());
        end
        rd(4'hC, 8'h00);
        $display("test fifo done");
        event_only_mode <= 1'b1;
        repeat (3) push(24'($urandom));
        rd(4'h6, 8'h00);
        while (q.size() > 0)
            rd(4'h7, 8'(q.pop_front()));
        $display("test event mode done");
        end_sim(1'b0);
    end
endmodule // tb
